//--- core_mem_pkg.sv
// Constants, states and timing for the core memory cycle control.
// Assumes a single 125 MHz system clock.
package core_mem_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int CSP_NS        = 50;
   localparam int XR_DELAY_NS   = 300;
   localparam int XR_WIDTH_NS   = 400;
   localparam int WS_LEAD_NS    = 100;
   localparam int WC_WIDTH_NS   = 400;
   // Least times round up to whole cycles
   localparam int CSP_CYC = (CSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XR_DELAY_CYC =
      (XR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XR_WIDTH_CYC =
      (XR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WS_LEAD_CYC =
      (WS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WC_WIDTH_CYC =
      (WC_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 7;
   // Address fields, bit 0 is the most significant
   localparam int BLK_LO  = 0;
   localparam int BLK_HI  = 2;
   localparam int COL_LO  = 3;
   localparam int COL_HI  = 6;
   localparam int LINE_LO = 7;
   localparam int LINE_HI = 10;
   localparam int WDIR    = 11;
   localparam int BSEL_LO = 12;
   localparam int BSEL_HI = 14;
   localparam int BDIR_A  = 4;
   localparam int BDIR_B  = 13;
   localparam int BDIR_C  = 14;
   localparam int HALFW   = 16;
   localparam int STACKW  = 18;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [15:0] DATA_RST = 16'h0000;
   typedef enum logic [6:0] {
      S_IDLE   = 7'h01,
      S_SAMPLE = 7'h02,
      S_BREAD  = 7'h04,
      S_XREAD  = 7'h08,
      S_WSW    = 7'h10,
      S_WCUR   = 7'h20,
      S_DONE   = 7'h40
   } cyc_state_e;
endpackage : core_mem_pkg

//--- level_sync.sv
// Two flip-flop synchroniser for one asynchronous level.
// Assumes sys_clk domain on the output side.
`timescale 1ns/1ps
module level_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_r;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_r   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : level_sync

//--- onehot_decoder.sv
// Gated one-of-N decoder for address select fields.
// Assumes select inputs are stable flip-flop outputs.
`timescale 1ns/1ps
module onehot_decoder #(
   parameter int W = 3
) (
   input  wire logic [W-1:0]      sel,
   input  wire logic              enable,
   output logic      [2**W-1:0]   dec
);
   localparam logic [2**W-1:0] ONE = {{(2**W-1){1'b0}}, 1'b1};
   assign dec = enable ? (ONE << sel) : '0;
endmodule : onehot_decoder

//--- core_mem_ctrl.sv
// Cycle control, address decode and data register of a halfword core
// memory. Assumes processor load strobes on sys_clk; request and write
// indication arrive asynchronously from the processor pins.
//
// Behaviour
// - 16-bit address, low bit not decoded
// - Block, word line, bit line fields
// - Bit 11 sets word current direction
// - Address loaded from source bus first
// - Data register from source/core, to result/core
// - Byte halves on bus, halfword to core
// - Odd parity per byte, two stages
// - Read switches complement write switches
// - Groups of eight; writes select ones
// - Eighteen wide with parity, else sixteen
// - Column and line select, sixteen each
// - Busy during requested operation
// - Request still low restarts cycle
// - Request launches 50 ns command sample
// - Erase then write strobe sequence
// - Erase-write leaves data register unchanged
// - Parity set at start, checked before write
// - Read clears register, restores captured data
// - Read valid withheld until data loaded
// - Alternate pairs of bit positions opposite direction
// - Bit line decode gated by enable
// - Enables only for fitted blocks
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
module core_mem_ctrl #(
   parameter logic       PARITY_FITTED = 1'b1,
   parameter logic [7:0] BLOCKS_FITTED = 8'hFF
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [0:15] source_bus,
   input  wire logic        address_low_half,
   input  wire logic        address_high_half,
   input  wire logic        data_low_half,
   input  wire logic        data_high_half,
   input  wire logic        cycle_request_n,
   input  wire logic        write_request,
   input  wire logic [0:17] core_read_data,
   output logic      [0:15] result_bus,
   output logic      [0:17] core_write_data,
   output logic             cycle_in_progress,
   output logic             command_sample_pulse,
   output logic             bit_read_strobe,
   output logic             word_read_strobe,
   output logic             write_switch_strobe,
   output logic             write_current_strobe,
   output logic             read_data_valid,
   output logic             data_high_clear,
   output logic             data_low_clear,
   output logic             parity_set,
   output logic             parity_check,
   output logic             parity_error,
   output logic      [7:0]  block_enable,
   output logic      [15:0] column_select,
   output logic      [15:0] line_select,
   output logic      [7:0]  bit_line_select,
   output logic      [0:17] bit_group_select,
   output logic      [0:17] bit_current_dir,
   output logic             word_current_dir
);
   localparam logic [core_mem_pkg::CNT_W-1:0] CSP_LD =
      core_mem_pkg::CNT_W'(core_mem_pkg::CSP_CYC - 1);
   localparam logic [core_mem_pkg::CNT_W-1:0] XRD_LD =
      core_mem_pkg::CNT_W'(core_mem_pkg::XR_DELAY_CYC - 1);
   localparam logic [core_mem_pkg::CNT_W-1:0] XRW_LD =
      core_mem_pkg::CNT_W'(core_mem_pkg::XR_WIDTH_CYC - 1);
   localparam logic [core_mem_pkg::CNT_W-1:0] WS_LD =
      core_mem_pkg::CNT_W'(core_mem_pkg::WS_LEAD_CYC - 1);
   localparam logic [core_mem_pkg::CNT_W-1:0] WC_LD =
      core_mem_pkg::CNT_W'(core_mem_pkg::WC_WIDTH_CYC - 1);

   core_mem_pkg::cyc_state_e        state_r;
   logic [core_mem_pkg::CNT_W-1:0]  cnt_r;
   logic [0:15]                     address_register_r;
   logic [0:15]                     data_register_r;
   logic [0:1]                      parity_r;
   logic                            op_write_r;
   logic                            busy_r;
   logic                            req_low;
   logic                            wr_sync;
   logic                            cnt_done;
   logic                            start_cycle;
   logic                            enter_bread;
   logic                            capture;
   logic                            enter_wsw;
   logic                            blk_ok;
   logic                            write_phase;
   logic                            bdir_base;
   logic [7:0]                      blk_dec;
   logic                            req_low_n;

   // request timing assumed; pin passes two flops first
   level_sync #(.RST_VAL(1'b1)) u_req_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .async_in (cycle_request_n),
      .sync_out (req_low_n)
   );
   assign req_low = ~req_low_n;

   level_sync #(.RST_VAL(1'b0)) u_wr_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .async_in (write_request),
      .sync_out (wr_sync)
   );

   assign cnt_done    = (cnt_r == '0);
   // level request: still low after busy restarts
   assign start_cycle = (state_r == core_mem_pkg::S_IDLE) && req_low;
   assign enter_bread = (state_r == core_mem_pkg::S_SAMPLE) && cnt_done;
   assign capture     = (state_r == core_mem_pkg::S_XREAD) && cnt_done;
   assign enter_wsw   = capture;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= core_mem_pkg::S_IDLE;
         cnt_r   <= '0;
      end else begin
         if (!cnt_done) begin
            cnt_r <= cnt_r - 1'b1;
         end
         unique case (state_r)
            core_mem_pkg::S_IDLE: begin
               if (req_low) begin
                  state_r <= core_mem_pkg::S_SAMPLE;
                  cnt_r   <= CSP_LD;
               end
            end
            core_mem_pkg::S_SAMPLE: begin
               if (cnt_done) begin
                  state_r <= core_mem_pkg::S_BREAD;
                  cnt_r   <= XRD_LD;
               end
            end
            core_mem_pkg::S_BREAD: begin
               if (cnt_done) begin
                  state_r <= core_mem_pkg::S_XREAD;
                  cnt_r   <= XRW_LD;
               end
            end
            core_mem_pkg::S_XREAD: begin
               if (cnt_done) begin
                  state_r <= core_mem_pkg::S_WSW;
                  cnt_r   <= WS_LD;
               end
            end
            core_mem_pkg::S_WSW: begin
               if (cnt_done) begin
                  state_r <= core_mem_pkg::S_WCUR;
                  cnt_r   <= WC_LD;
               end
            end
            core_mem_pkg::S_WCUR: begin
               if (cnt_done) begin
                  state_r <= core_mem_pkg::S_DONE;
               end
            end
            core_mem_pkg::S_DONE: begin
               state_r <= core_mem_pkg::S_IDLE;
            end
            default: begin
               state_r <= core_mem_pkg::S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         busy_r <= 1'b0;
      end else if (start_cycle) begin
         busy_r <= 1'b1;
      end else if (state_r == core_mem_pkg::S_DONE) begin
         busy_r <= 1'b0;
      end
   end

   // operation sampled at end of command pulse
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         op_write_r <= 1'b0;
      end else if (enter_bread) begin
         op_write_r <= wr_sync;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         address_register_r <= core_mem_pkg::ADDR_RST;
      end else if (!busy_r) begin
         if (address_high_half) begin
            address_register_r[0:7] <= source_bus[0:7];
         end
         if (address_low_half) begin
            address_register_r[8:15] <= source_bus[8:15];
         end
      end
   end

   // data register: bus byte halves, core halfword
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         data_register_r <= core_mem_pkg::DATA_RST;
      end else if (!busy_r) begin
         if (data_high_half) begin
            data_register_r[0:7] <= source_bus[0:7];
         end
         if (data_low_half) begin
            data_register_r[8:15] <= source_bus[8:15];
         end
      end else if (enter_bread && !wr_sync) begin
         // clear on the fresh operation, not the stale one
         data_register_r <= '0;
      end else if (capture && !op_write_r) begin
         data_register_r <= core_read_data[0:15];
      end
   end

   // clear strobes; valid only after capture
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         data_high_clear <= 1'b0;
         data_low_clear  <= 1'b0;
         read_data_valid <= 1'b0;
      end else begin
         data_high_clear <= enter_bread && !wr_sync;
         data_low_clear  <= enter_bread && !wr_sync;
         read_data_valid <= capture && !op_write_r;
      end
   end

   // odd parity per byte, set and checked
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         parity_r     <= 2'b00;
         parity_set   <= 1'b0;
         parity_check <= 1'b0;
         parity_error <= 1'b0;
      end else begin
         parity_set   <= PARITY_FITTED && start_cycle;
         parity_check <= PARITY_FITTED && enter_wsw;
         if (PARITY_FITTED && start_cycle) begin
            parity_r[0]  <= ~^data_register_r[0:7];
            parity_r[1]  <= ~^data_register_r[8:15];
            parity_error <= 1'b0;
         end else if (PARITY_FITTED && capture && !op_write_r) begin
            parity_r <= core_read_data[16:17];
         end else if (parity_check) begin
            parity_error <=
               (parity_r[0] != ~^data_register_r[0:7]) ||
               (parity_r[1] != ~^data_register_r[8:15]);
         end
      end
   end

   // Strobes straight from one-hot state flops
   // bit read first, word read after delay
   assign command_sample_pulse = (state_r == core_mem_pkg::S_SAMPLE);
   assign bit_read_strobe      = (state_r == core_mem_pkg::S_BREAD) ||
                                 (state_r == core_mem_pkg::S_XREAD);
   assign word_read_strobe     = (state_r == core_mem_pkg::S_XREAD);
   assign write_switch_strobe  = (state_r == core_mem_pkg::S_WSW) ||
                                 (state_r == core_mem_pkg::S_WCUR);
   assign write_current_strobe = (state_r == core_mem_pkg::S_WCUR);
   assign write_phase          = write_switch_strobe;
   assign cycle_in_progress    = busy_r;
   assign result_bus           = data_register_r;

   // restore writes back the captured data
   assign core_write_data = {data_register_r,
                             PARITY_FITTED ? parity_r : 2'b00};

   // block enables only for fitted blocks
   assign blk_ok = BLOCKS_FITTED[address_register_r[
                      core_mem_pkg::BLK_LO:core_mem_pkg::BLK_HI]];
   onehot_decoder #(.W(3)) u_blk_dec (
      .sel    (address_register_r[
                  core_mem_pkg::BLK_LO:core_mem_pkg::BLK_HI]),
      .enable (busy_r && blk_ok),
      .dec    (blk_dec)
   );
   assign block_enable = blk_dec;

   onehot_decoder #(.W(4)) u_col_dec (
      .sel    (address_register_r[
                  core_mem_pkg::COL_LO:core_mem_pkg::COL_HI]),
      .enable (|blk_dec),
      .dec    (column_select)
   );
   onehot_decoder #(.W(4)) u_line_dec (
      .sel    (address_register_r[
                  core_mem_pkg::LINE_LO:core_mem_pkg::LINE_HI]),
      .enable (|blk_dec),
      .dec    (line_select)
   );

   // bit line decode gated by block enable
   onehot_decoder #(.W(3)) u_bsel_dec (
      .sel    (address_register_r[
                  core_mem_pkg::BSEL_LO:core_mem_pkg::BSEL_HI]),
      .enable (|blk_dec),
      .dec    (bit_line_select)
   );

   assign word_current_dir =
      address_register_r[core_mem_pkg::WDIR] ^ write_phase;

   assign bdir_base = address_register_r[core_mem_pkg::BDIR_A] ^
                      address_register_r[core_mem_pkg::BDIR_B] ^
                      address_register_r[core_mem_pkg::BDIR_C];

   always_comb begin
      bit_group_select = '0;
      bit_current_dir  = '0;
      for (int k = 0; k < core_mem_pkg::STACKW; k++) begin
         if (k < core_mem_pkg::HALFW || PARITY_FITTED) begin
            bit_current_dir[k] = bdir_base ^ k[1] ^ write_phase;
            if (bit_read_strobe && (|blk_dec)) begin
               bit_group_select[k] = 1'b1;
            end else if (write_current_strobe && (|blk_dec)) begin
               bit_group_select[k] = core_write_data[k];
            end
         end
      end
   end

   // Assertions
   property p_busy_on;
      @(posedge sys_clk) disable iff (sys_rst)
      start_cycle |=> cycle_in_progress;
   endproperty
   a_busy_on: assert property (p_busy_on)
      else $error("busy not raised after request");

   property p_csp_width;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(command_sample_pulse) |->
         command_sample_pulse[*7] ##1 !command_sample_pulse;
   endproperty
   a_csp_width: assert property (p_csp_width)
      else $error("command sample pulse not 7 cycles");

   property p_xr_delay;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(bit_read_strobe) |-> ##38 $rose(word_read_strobe);
   endproperty
   a_xr_delay: assert property (p_xr_delay)
      else $error("word read not 38 cycles after bit read");

   property p_ws_first;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(write_current_strobe) |->
         $past(write_switch_strobe) && !word_read_strobe;
   endproperty
   a_ws_first: assert property (p_ws_first)
      else $error("write current without write switch");

   property p_eaw_stable;
      @(posedge sys_clk) disable iff (sys_rst)
      (busy_r && op_write_r && !enter_bread) |=> $stable(result_bus);
   endproperty
   a_eaw_stable: assert property (p_eaw_stable)
      else $error("data register changed in erase-write");

   property p_rdv_after_load;
      @(posedge sys_clk) disable iff (sys_rst)
      read_data_valid |-> !op_write_r &&
         result_bus == $past(core_read_data[0:15]);
   endproperty
   a_rdv_after_load: assert property (p_rdv_after_load)
      else $error("read valid without loaded data");

   property p_clear_before_read;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(word_read_strobe) && !op_write_r |-> result_bus == '0;
   endproperty
   a_clear_before_read: assert property (p_clear_before_read)
      else $error("data register not cleared before read");

   property p_addr_locked;
      @(posedge sys_clk) disable iff (sys_rst)
      busy_r |=> $stable(address_register_r);
   endproperty
   a_addr_locked: assert property (p_addr_locked)
      else $error("address changed during cycle");

   property p_word_dir;
      @(posedge sys_clk) disable iff (sys_rst)
      write_current_strobe |->
         word_current_dir == ~address_register_r[core_mem_pkg::WDIR];
   endproperty
   a_word_dir: assert property (p_word_dir)
      else $error("word current not reversed for write");

   property p_bitline_gate;
      @(posedge sys_clk) disable iff (sys_rst)
      !busy_r |-> bit_line_select == '0 && block_enable == '0;
   endproperty
   a_bitline_gate: assert property (p_bitline_gate)
      else $error("bit line select without enable");

   property p_restart;
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == core_mem_pkg::S_DONE) && req_low |=>
         ##1 command_sample_pulse;
   endproperty
   a_restart: assert property (p_restart)
      else $error("held request did not restart");

   c_write: cover property (@(posedge sys_clk)
      $rose(write_current_strobe) && op_write_r);
   c_read: cover property (@(posedge sys_clk) read_data_valid);
   c_restart: cover property (@(posedge sys_clk)
      (state_r == core_mem_pkg::S_DONE) && req_low);
   c_perr: cover property (@(posedge sys_clk) $rose(parity_error));
endmodule : core_mem_ctrl

//--- proc_model.sv
// Processor side model: loads registers, then requests cycles.
// Assumes it is stepped from sys_clk rising edges by the bench.
`timescale 1ns/1ps
module proc_model (
   input  wire logic        sys_clk,
   input  wire logic        cycle_in_progress,
   output logic      [0:15] source_bus,
   output logic             address_low_half,
   output logic             address_high_half,
   output logic             data_low_half,
   output logic             data_high_half,
   output logic             cycle_request_n,
   output logic             write_request
);
   logic [3:0] ld;
   assign {address_low_half, address_high_half} = ld[3:2];
   assign {data_low_half, data_high_half} = ld[1:0];
   initial begin
      ld = 4'h0;
      source_bus = 16'h0000;
      cycle_request_n = 1'b1;
      write_request = 1'b0;
   end
   // Bus released: shows inverse, never the stale value
   task automatic put(input logic [3:0] s, input logic [0:15] v);
      ld <= s;
      source_bus <= v;
      @(posedge sys_clk);
      ld <= 4'h0;
      source_bus <= ~v;
      @(posedge sys_clk);
   endtask : put
   // address halves first, then data halves
   task automatic load(input logic [0:15] a, d, input logic pair);
      if (pair) begin
         put(4'hC, a);
         put(4'h3, d);
      end else begin
         put(4'h8, a);
         put(4'h4, a);
         put(4'h2, d);
         put(4'h1, d);
      end
   endtask : load
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (cycle_in_progress !== lvl && n < 400);
   endtask : wait_busy
   // held past the sample, high well before next cycle unless keep is set
   task automatic run(input logic wr, input logic keep,
                      output logic again);
      write_request <= wr;
      cycle_request_n <= 1'b0;
      wait_busy(1'b1);
      repeat (core_mem_pkg::CSP_CYC + 2) @(posedge sys_clk);
      if (!keep)
         cycle_request_n <= 1'b1;
      repeat (30) @(posedge sys_clk);
      // Stray load while busy, must be ignored
      put(4'h2, 16'h5A5A);
      wait_busy(1'b0);
      repeat (3) @(posedge sys_clk);
      #1 again = cycle_in_progress;
      @(posedge sys_clk);
      cycle_request_n <= 1'b1;
      wait_busy(1'b0);
      repeat (core_mem_pkg::CSP_CYC + 2) @(posedge sys_clk);
   endtask : run
endmodule : proc_model

//--- tb_core_mem_ctrl.sv
// Bench for the core memory cycle control: random cycles vs a model.
// Assumes proc_model drives processor pins; bench drives sense data.
`timescale 1ns/1ps
module tb_core_mem_ctrl;
   localparam int TOTAL = core_mem_pkg::CSP_CYC
      + core_mem_pkg::XR_DELAY_CYC + core_mem_pkg::XR_WIDTH_CYC
      + core_mem_pkg::WS_LEAD_CYC + core_mem_pkg::WC_WIDTH_CYC + 1;
   logic        sys_clk, sys_rst;
   logic [0:15] source_bus, result_bus, ea, ed, d;
   logic        adl, adh, dl, dh, req_n, wr;
   logic [0:17] rd, core_write_data, ew, bit_group_select, bit_current_dir;
   logic        cycle_in_progress, command_sample_pulse, bit_read_strobe;
   logic        word_read_strobe, write_switch_strobe, write_current_strobe;
   logic        read_data_valid, data_high_clear, data_low_clear;
   logic        parity_set, parity_check, parity_error, word_current_dir;
   logic [7:0]  block_enable, bit_line_select;
   logic [15:0] column_select, line_select;
   logic        erd, ef, bp, ag;
   int busy_n, csp_n, bro_n, wc_n, rdv_n, clr_n, pp_n, bad, xr_n, ws_n;
   int n_errors, check_count, i, k;

   core_mem_ctrl #(.PARITY_FITTED(1'b1), .BLOCKS_FITTED(8'h7F)) dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .source_bus(source_bus),
      .address_low_half(adl), .address_high_half(adh),
      .data_low_half(dl), .data_high_half(dh), .cycle_request_n(req_n),
      .write_request(wr), .core_read_data(rd), .result_bus(result_bus),
      .core_write_data(core_write_data),
      .cycle_in_progress(cycle_in_progress),
      .command_sample_pulse(command_sample_pulse),
      .bit_read_strobe(bit_read_strobe),
      .word_read_strobe(word_read_strobe),
      .write_switch_strobe(write_switch_strobe),
      .write_current_strobe(write_current_strobe),
      .read_data_valid(read_data_valid),
      .data_high_clear(data_high_clear), .data_low_clear(data_low_clear),
      .parity_set(parity_set), .parity_check(parity_check),
      .parity_error(parity_error), .block_enable(block_enable),
      .column_select(column_select), .line_select(line_select),
      .bit_line_select(bit_line_select),
      .bit_group_select(bit_group_select),
      .bit_current_dir(bit_current_dir),
      .word_current_dir(word_current_dir));

   proc_model pm (
      .sys_clk(sys_clk), .cycle_in_progress(cycle_in_progress),
      .source_bus(source_bus), .address_low_half(adl),
      .address_high_half(adh), .data_low_half(dl), .data_high_half(dh),
      .cycle_request_n(req_n), .write_request(wr));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Cycle-by-cycle model of strobes and selects while busy
   always @(posedge sys_clk) begin
      if (cycle_in_progress === 1'b1) begin
         busy_n++;
         csp_n += command_sample_pulse;
         bro_n += bit_read_strobe & ~word_read_strobe;
         wc_n += write_current_strobe;
         xr_n += word_read_strobe;
         ws_n += write_switch_strobe & ~write_current_strobe;
         rdv_n += read_data_valid;
         clr_n += data_high_clear + data_low_clear;
         pp_n += parity_set + parity_check;
         if (block_enable !== (ef ? 8'h01 << ea[0:2] : 8'h00)) bad++;
         if (column_select !== (ef ? 16'h1 << ea[3:6] : 16'h0)) bad++;
         if (line_select !== (ef ? 16'h1 << ea[7:10] : 16'h0)) bad++;
         if (bit_line_select !== (ef ? 8'h01 << ea[12:14] : 8'h00)) bad++;
         if (ef && word_current_dir !== (ea[11] ^ write_switch_strobe))
            bad++;
         for (k = 0; k < 18; k++)
            if (ef && bit_current_dir[k] !== (ea[4] ^ ea[13] ^ ea[14]
                ^ k[1] ^ write_switch_strobe)) bad++;
         if (ef && bit_read_strobe && bit_group_select !== 18'h3FFFF) bad++;
         if (ef && write_current_strobe && (bit_group_select[0:15]
             !== ew[0:15] || (!erd && bit_group_select !== ew))) bad++;
         if (read_data_valid && result_bus !== ed) bad++;
         if (erd && word_read_strobe && result_bus !== 16'h0000) bad++;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("Checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   initial begin
      #(8 * 5000);
      n_errors++;
      $display("ERROR watchdog expected done seen hang");
      report_and_stop();
   end

   initial begin
      sys_rst = 1'b1;
      rd = 18'h00000;
      ef = 1'b1;
      erd = 1'b0;
      void'($urandom(2370));
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("idle busy", 0, cycle_in_progress);
      chk("reset data", 0, result_bus);
      chk("idle enable", 0, block_enable);
      for (i = 0; i < 9; i++) begin
         ea = 16'($urandom);
         d = 16'($urandom);
         if (i == 6)
            ea[0:2] = 3'h7;
         else if (i == 3)
            ea[0] = 1'b0;
         ef = ea[0:2] != 3'h7;
         erd = i[0] && ef;
         bp = i == 3;
         rd <= {16'($urandom), 2'b00};
         pm.load(ea, d, i[1]);
         chk("loaded data", d, result_bus);
         rd[16] <= ~^rd[0:7] ^ bp;
         rd[17] <= ~^rd[8:15];
         @(posedge sys_clk);
         ed = erd ? rd[0:15] : d;
         ew = erd ? rd : {d, ~^d[0:7], ~^d[8:15]};
         {busy_n, csp_n, bro_n, wc_n, rdv_n, clr_n, pp_n, bad} = '0;
         {xr_n, ws_n} = '0;
         pm.run(~erd, 1'b0, ag);
         chk("no restart", 0, ag);
         chk("busy cycles", TOTAL, busy_n);
         chk("sample", core_mem_pkg::CSP_CYC, csp_n);
         chk("bit lead", core_mem_pkg::XR_DELAY_CYC, bro_n);
         chk("write cur", core_mem_pkg::WC_WIDTH_CYC, wc_n);
         chk("word read", core_mem_pkg::XR_WIDTH_CYC, xr_n);
         chk("switch lead", core_mem_pkg::WS_LEAD_CYC, ws_n);
         chk("valid", erd, rdv_n);
         chk("clears", erd ? 2 : 0, clr_n);
         chk("parity pulses", 2, pp_n);
         chk("decode", 0, bad);
         chk("data", ed, result_bus);
         chk("core data", ew[0:15], core_write_data[0:15]);
         if (!erd)
            chk("core parity", ew[16:17], core_write_data[16:17]);
         chk("parity error", bp, parity_error);
      end
      pm.load(16'h1234, 16'h00FF, 1'b1);
      pm.run(1'b1, 1'b1, ag);
      chk("restart", 1, ag);
      report_and_stop();
   end
endmodule : tb_core_mem_ctrl
